/* File: core/csef_regs.v */
// Summary of operation
// RULE1 - thermistor zone reported in bits 2:0 of 0x0d with fixed zone codes
// RULE2 - all reserved bits in these registers read as zero
// RULE3 - fault bit 7 shows input over-voltage protection active
// RULE4 - fault bit 6 shows die thermal shutdown active
// RULE5 - fault bit 4 shows charge safety timer expired
// RULE6 - flag one bit 6 latches on input current regulation rising edge
// RULE7 - flag one bit 5 latches on input voltage regulation rising edge
// RULE8 - flag one bit 4 latches on die thermal regulation rising edge
// RULE9 - flag one bit 3 latches on watchdog-expired status rising edge
// RULE10 - flag one bit 0 latches on any charge phase change
// RULE11 - flag two bit 7 latches on power-good toggle either way
// RULE12 - flag two bit 4 latches on any input source type change
// RULE13 - flag two bit 2 latches on any thermistor zone change
// RULE14 - flag two bit 1 latches on any optimizer state change
// RULE15 - flags reset to zero on register reset, not on watchdog expiry
// RULE16 - unmasked flagged events give an interrupt pulse; masked ones do not
// RULE17 - flag holds until its register is read; a same-cycle event wins
// RULE18 - status fields follow live inputs; detection uses registered previous values
`timescale 1ns/10ps
`default_nettype none
`include "csef_map.vh"
module csef_regs (
  // clock and reset
  input wire clk_i,
  input wire reset_n_i,
  // software register reset, one-cycle pulse
  input wire reg_reset_i,
  // live charger conditions
  input wire [2:0] thermistor_zone_i,
  input wire input_overvoltage_active_i,
  input wire thermal_shutdown_active_i,
  input wire safety_timer_expired_i,
  input wire input_current_regulation_i,
  input wire input_voltage_regulation_i,
  input wire die_thermal_regulation_i,
  input wire watchdog_expired_status_i,
  input wire [2:0] charge_phase_i,
  input wire power_good_i,
  input wire [2:0] input_source_type_i,
  input wire [1:0] input_optimizer_state_i,
  // mask bits from the mask registers kept elsewhere, 1 suppresses
  input wire [7:0] flag1_mask_i,
  input wire [7:0] flag2_mask_i,
  // host register read port
  input wire rd_en_i,
  input wire [7:0] rd_addr_i,
  output reg [7:0] rd_data_o,
  // interrupt request pulse
  output reg int_pulse_o
);
  reg [2:0] zone_r;
  reg ovp_r;
  reg tshut_r;
  reg tmr_r;
  reg icr_r;
  reg ivr_r;
  reg dtr_r;
  reg wde_r;
  reg [2:0] phase_r;
  reg pg_r;
  reg [2:0] src_r;
  reg [1:0] opt_r;
  reg [7:0] flag1_r;
  reg [7:0] flag2_r;
  reg [7:0] flag1_nxt;
  reg [7:0] flag2_nxt;
  reg [7:0] rd_data_nxt;
  reg [7:0] zone_byte;
  reg [7:0] fault_byte;
  wire [7:0] ev1;
  wire [7:0] ev2;
  wire rd1;
  wire rd2;

  // sample live conditions once; status reads and detectors share these copies
  // no reset here: a zero reset value against a nonzero live input would be a false edge
  always @(posedge clk_i) begin
    zone_r <= thermistor_zone_i; // see RULE18
    ovp_r <= input_overvoltage_active_i;
    tshut_r <= thermal_shutdown_active_i;
    tmr_r <= safety_timer_expired_i;
    icr_r <= input_current_regulation_i;
    ivr_r <= input_voltage_regulation_i;
    dtr_r <= die_thermal_regulation_i;
    wde_r <= watchdog_expired_status_i;
    phase_r <= charge_phase_i;
    pg_r <= power_good_i;
    src_r <= input_source_type_i;
    opt_r <= input_optimizer_state_i;
  end

  // rising-edge detectors on the single-bit conditions
  csef_edge #(.W(1), .RISE_ONLY(1)) u_icr (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .val_i(icr_r), .evt_o(ev1[`CSEF_F1_ICR])); // see RULE6
  csef_edge #(.W(1), .RISE_ONLY(1)) u_ivr (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .val_i(ivr_r), .evt_o(ev1[`CSEF_F1_IVR])); // see RULE7
  csef_edge #(.W(1), .RISE_ONLY(1)) u_dtr (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .val_i(dtr_r), .evt_o(ev1[`CSEF_F1_DTR])); // see RULE8
  csef_edge #(.W(1), .RISE_ONLY(1)) u_wde (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .val_i(wde_r), .evt_o(ev1[`CSEF_F1_WDE])); // see RULE9
  // any-change detectors on fields and on power good
  csef_edge #(.W(3), .RISE_ONLY(0)) u_chg (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .val_i(phase_r), .evt_o(ev1[`CSEF_F1_CHG])); // see RULE10
  csef_edge #(.W(1), .RISE_ONLY(0)) u_pg (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .val_i(pg_r), .evt_o(ev2[`CSEF_F2_PG])); // see RULE11
  csef_edge #(.W(3), .RISE_ONLY(0)) u_src (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .val_i(src_r), .evt_o(ev2[`CSEF_F2_SRC])); // see RULE12
  csef_edge #(.W(3), .RISE_ONLY(0)) u_tz (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .val_i(zone_r), .evt_o(ev2[`CSEF_F2_TZ])); // see RULE13
  csef_edge #(.W(2), .RISE_ONLY(0)) u_opt (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .val_i(opt_r), .evt_o(ev2[`CSEF_F2_OPT])); // see RULE14

  // unused event positions are reserved and never set
  assign ev1[7] = 1'b0;
  assign ev1[2:1] = 2'h0;
  assign ev2[6:5] = 2'h0;
  assign ev2[3] = 1'b0;
  assign ev2[0] = 1'b0;

  assign rd1 = rd_en_i && (rd_addr_i == `CSEF_OFS_FLAG1);
  assign rd2 = rd_en_i && (rd_addr_i == `CSEF_OFS_FLAG2);

  // sticky flags: read clears, but a same-cycle event is kept
  always @* begin
    flag1_nxt = (rd1 ? `CSEF_FLAGS_RST : flag1_r) | ev1; // see RULE17
    flag2_nxt = (rd2 ? `CSEF_FLAGS_RST : flag2_r) | ev2; // see RULE17
  end

  // watchdog expiry is deliberately not an input here, so it cannot clear the flags
  always @(posedge clk_i) begin
    if (!reset_n_i || reg_reset_i) begin
      flag1_r <= `CSEF_FLAGS_RST; // see RULE15
      flag2_r <= `CSEF_FLAGS_RST; // see RULE15
    end else begin
      flag1_r <= flag1_nxt;
      flag2_r <= flag2_nxt;
    end
  end

  // status bytes built from live samples, reserved bits held at zero
  always @* begin
    zone_byte = `CSEF_BYTE_ZERO; // see RULE2
    zone_byte[`CSEF_ZONE_MSB:`CSEF_ZONE_LSB] = zone_r; // see RULE1
    fault_byte = `CSEF_BYTE_ZERO;
    fault_byte[`CSEF_FLT_OVP] = ovp_r; // see RULE3
    fault_byte[`CSEF_FLT_TSHUT] = tshut_r; // see RULE4
    fault_byte[`CSEF_FLT_TMR] = tmr_r; // see RULE5
  end

  // read mux; flag reads return the value before the clear
  always @* begin
    case (rd_addr_i)
      `CSEF_OFS_ZONE: begin
        rd_data_nxt = zone_byte;
      end
      `CSEF_OFS_FAULT: begin
        rd_data_nxt = fault_byte;
      end
      `CSEF_OFS_FLAG1: begin
        rd_data_nxt = flag1_r;
      end
      `CSEF_OFS_FLAG2: begin
        rd_data_nxt = flag2_r;
      end
      default: begin
        rd_data_nxt = `CSEF_BYTE_ZERO; // see RULE2
      end
    endcase
  end

  // registered read data and interrupt pulse
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      rd_data_o <= `CSEF_BYTE_ZERO;
      int_pulse_o <= 1'b0;
    end else begin
      if (rd_en_i) begin
        rd_data_o <= rd_data_nxt;
      end
      // pulses per event, not per flag, so a still-set flag can fire again
      int_pulse_o <= |((ev1 & ~flag1_mask_i) | (ev2 & ~flag2_mask_i)); // see RULE16
    end
  end
endmodule
`default_nettype wire

/* File: core/csef_map.vh */
`ifndef CSEF_MAP_VH
`define CSEF_MAP_VH
// register offsets on the host register port
`define CSEF_OFS_ZONE 8'h0d
`define CSEF_OFS_FAULT 8'h0e
`define CSEF_OFS_FLAG1 8'h0f
`define CSEF_OFS_FLAG2 8'h10
// thermistor zone field of the zone status register
`define CSEF_ZONE_LSB 0
`define CSEF_ZONE_MSB 2
// thermistor zone codes
`define CSEF_ZONE_NORMAL 3'h0
`define CSEF_ZONE_WARM 3'h2
`define CSEF_ZONE_COOL 3'h3
`define CSEF_ZONE_COLD 3'h5
`define CSEF_ZONE_HOT 3'h6
// fault status bits
`define CSEF_FLT_OVP 7
`define CSEF_FLT_TSHUT 6
`define CSEF_FLT_TMR 4
// first event-flag register bits
`define CSEF_F1_ICR 6
`define CSEF_F1_IVR 5
`define CSEF_F1_DTR 4
`define CSEF_F1_WDE 3
`define CSEF_F1_CHG 0
// second event-flag register bits
`define CSEF_F2_PG 7
`define CSEF_F2_SRC 4
`define CSEF_F2_TZ 2
`define CSEF_F2_OPT 1
// reset values
`define CSEF_FLAGS_RST 8'h00
`define CSEF_BYTE_ZERO 8'h00
`endif

/* File: core/csef_edge.v */
`timescale 1ns/10ps
`default_nettype none
// change or rising-edge detector against a registered previous value
module csef_edge #(
  parameter W = 1,
  parameter RISE_ONLY = 0
) (
  // clock and reset
  input wire clk_i,
  input wire reset_n_i,
  // live value
  input wire [W-1:0] val_i,
  // one-cycle event
  output wire evt_o
);
  reg [W-1:0] prev_r;
  reg armed_r;

  // previous value; no event until one sample is held, so reset is not an edge
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      prev_r <= {W{1'b0}};
      armed_r <= 1'b0;
    end else begin
      prev_r <= val_i;
      armed_r <= 1'b1;
    end
  end

  assign evt_o = armed_r & (RISE_ONLY ? (val_i[0] & ~prev_r[0]) : (val_i != prev_r));
endmodule
`default_nettype wire

/* File: dv/csef_host.sv */
`timescale 1ns/10ps
`default_nettype none
module csef_host (
  // clock
  input wire logic clk_i,
  // read port drive
  output logic rd_en_o,
  output logic [7:0] rd_addr_o
);
  initial begin
    rd_en_o = 1'b0;
    rd_addr_o = 8'h00;
  end
  // calls back to back give one read every cycle
  task rd(input logic [7:0] a);
    @(posedge clk_i);
    rd_en_o <= 1'b1;
    rd_addr_o <= a;
  endtask
  // offset toggles while idle so a stale value never looks valid
  task idle();
    @(posedge clk_i);
    rd_en_o <= 1'b0;
    rd_addr_o <= ~rd_addr_o;
  endtask
endmodule
`default_nettype wire

/* File: dv/csef_regs_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module csef_regs_chk (
  // clock and reset
  input wire clk_i,
  input wire reset_n_i,
  // watched inputs
  input wire reg_reset_i,
  input wire [2:0] thermistor_zone_i,
  input wire input_overvoltage_active_i,
  input wire thermal_shutdown_active_i,
  input wire safety_timer_expired_i,
  input wire power_good_i,
  input wire [7:0] flag2_mask_i,
  input wire rd_en_i,
  input wire [7:0] rd_addr_i,
  // watched outputs
  input wire [7:0] rd_data_o,
  input wire int_pulse_o
);
  logic [2:0] up_r;
  logic ok;
  // edges since reset, so $past never looks back into reset
  always @(posedge clk_i) begin
    if (!reset_n_i) up_r <= 3'h0;
    else if (!ok) up_r <= up_r + 3'h1;
  end
  assign ok = (up_r == 3'h4);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  a_zone_read: assert property (
    ok && rd_en_i && rd_addr_i == 8'h0d |=> rd_data_o == {5'h00, $past(thermistor_zone_i, 2)}
  ) else $error("zone read wrong");
  a_fault_read: assert property (
    ok && rd_en_i && rd_addr_i == 8'h0e |=> rd_data_o == {$past(input_overvoltage_active_i, 2),
    $past(thermal_shutdown_active_i, 2), 1'b0, $past(safety_timer_expired_i, 2), 4'h0}
  ) else $error("fault read wrong");
  a_flag1_rsvd: assert property (
    rd_en_i && rd_addr_i == 8'h0f |=> (rd_data_o & 8'h86) == 8'h00
  ) else $error("flag one reserved bit set");
  a_flag2_rsvd: assert property (
    rd_en_i && rd_addr_i == 8'h10 |=> (rd_data_o & 8'h69) == 8'h00
  ) else $error("flag two reserved bit set");
  a_unmapped_zero: assert property (
    rd_en_i && (rd_addr_i < 8'h0d || rd_addr_i > 8'h10) |=> rd_data_o == 8'h00
  ) else $error("unmapped read not zero");
  a_data_holds: assert property (
    !rd_en_i |=> $stable(rd_data_o)
  ) else $error("read data moved without read");
  a_regrst_clears: assert property (
    reg_reset_i ##1 (rd_en_i && rd_addr_i == 8'h0f) |=> rd_data_o == 8'h00
  ) else $error("flags survive register reset");
  a_pg_int: assert property (
    ok && $past(power_good_i, 2) != $past(power_good_i, 3) && !$past(flag2_mask_i[7])
    && !$past(flag2_mask_i[7], 2) |-> int_pulse_o
  ) else $error("power good toggle gave no pulse");
  c_flag_b2b: cover property (rd_en_i && rd_addr_i == 8'h0f ##1 rd_en_i && rd_addr_i == 8'h0f);
  c_int_run: cover property (int_pulse_o ##1 int_pulse_o);
  c_regrst: cover property (reg_reset_i);
endmodule
bind csef_regs csef_regs_chk chk_u (.clk_i, .reset_n_i, .reg_reset_i, .thermistor_zone_i,
  .input_overvoltage_active_i, .thermal_shutdown_active_i, .safety_timer_expired_i,
  .power_good_i, .flag2_mask_i, .rd_en_i, .rd_addr_i, .rd_data_o, .int_pulse_o);
`default_nettype wire

/* File: dv/csef_regs_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module csef_regs_tb;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic reg_reset_i = 1'b0;
  logic [18:0] lv = 19'h0; // live conditions, packed
  logic [7:0] m1 = 8'h00, m2 = 8'h00, rd_addr, rd_data, f1, f2, e1, e2, exp_rd;
  logic rd_en, int_p, exp_int, chk;
  logic [18:0] s, p;
  integer fails = 0, cmp_count = 0, seed = 32'h25c33369, i, j;
  initial forever #2 clk_i = ~clk_i;
  csef_host h (.clk_i(clk_i), .rd_en_o(rd_en), .rd_addr_o(rd_addr));
  csef_regs dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .reg_reset_i(reg_reset_i),
    .thermistor_zone_i(lv[18:16]), .input_overvoltage_active_i(lv[15]),
    .thermal_shutdown_active_i(lv[14]), .safety_timer_expired_i(lv[13]),
    .input_current_regulation_i(lv[12]), .input_voltage_regulation_i(lv[11]),
    .die_thermal_regulation_i(lv[10]), .watchdog_expired_status_i(lv[9]),
    .charge_phase_i(lv[8:6]), .power_good_i(lv[5]), .input_source_type_i(lv[4:2]),
    .input_optimizer_state_i(lv[1:0]), .flag1_mask_i(m1), .flag2_mask_i(m2),
    .rd_en_i(rd_en), .rd_addr_i(rd_addr), .rd_data_o(rd_data), .int_pulse_o(int_p));
  // model events: rising edges on flag one bits 6 to 3, any change elsewhere
  assign e1 = {1'b0, s[12:9] & ~p[12:9], 2'b0, s[8:6] != p[8:6]};
  assign e2 = {s[5] ^ p[5], 2'b0, s[4:2] != p[4:2], 1'b0, s[18:16] != p[18:16],
    s[1:0] != p[1:0], 1'b0};
  // model: one sample stage, read clears, new event wins over clear
  always @(posedge clk_i) begin
    s <= lv;
    p <= s;
    exp_int <= reset_n_i && ((|(e1 & ~m1)) || (|(e2 & ~m2)));
    chk <= rd_en;
    case (rd_addr)
      8'h0d: exp_rd <= {5'h00, s[18:16]};
      8'h0e: exp_rd <= {s[15:14], 1'b0, s[13], 4'h0};
      8'h0f: exp_rd <= f1;
      8'h10: exp_rd <= f2;
      default: exp_rd <= 8'h00;
    endcase
    f1 <= (!reset_n_i || reg_reset_i) ? 8'h00 : ((rd_en && rd_addr == 8'h0f) ? 8'h00 : f1) | e1;
    f2 <= (!reset_n_i || reg_reset_i) ? 8'h00 : ((rd_en && rd_addr == 8'h10) ? 8'h00 : f2) | e2;
  end
  task chk_rd(input logic [7:0] e, g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("Error rd_data exp %h got %h", e, g);
    end
  endtask
  task chk_int(input logic e, g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("Error int_pulse exp %h got %h", e, g);
    end
  endtask
  // compare on the falling edge, where every output has settled
  always @(negedge clk_i) if (reset_n_i) begin
    chk_int(exp_int, int_p);
    if (chk) chk_rd(exp_rd, rd_data);
  end
  task wrap_up();
    if (fails == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // the run needs about 2000 ns; ten times that means a hang
  initial begin
    #20000;
    fails++;
    wrap_up();
  end
  initial begin
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (3) h.idle();
    for (i = 12; i < 18; i++) h.rd(8'(i));
    h.rd(8'hff);
    // every zone code read back, flag two right behind it
    for (i = 0; i < 5; i++) begin
      lv[18:16] <= 3'(32'h65320 >> (4 * i));
      repeat (2) h.idle();
      h.rd(8'h0d);
      h.rd(8'h10);
    end
    // random traffic; masks change only while inputs are quiet
    for (i = 0; i < 40; i++) begin
      repeat (3) h.idle();
      m1 <= 8'($random(seed));
      m2 <= 8'($random(seed));
      for (j = 0; j < 8; j++) begin
        lv <= 19'($random(seed));
        reg_reset_i <= ($random(seed) & 15) == 0;
        if ($random(seed) & 1) h.rd(8'(12 + {$random(seed)} % 6));
        else h.idle();
      end
      reg_reset_i <= 1'b0;
    end
    reg_reset_i <= 1'b1;
    h.idle();
    reg_reset_i <= 1'b0;
    h.rd(8'h0f);
    h.rd(8'h10);
    repeat (3) h.idle();
    wrap_up();
  end
endmodule
`default_nettype wire
